/* File: aer_uncorrectable_error_regs.sv */
// Purpose: Error reporting capability header, uncorrectable status and mask
// Assumes: AXI4-Lite slave, one clock, events one bit per error source
// Notes: Unmapped addresses answer SLVERR; reads of them return zero
// Functional notes
// [RL1] Header bits 15:0 read 0001h, read-only
// [RL2] Header bits 19:16 read version 1h
// [RL3] Header bits 31:20 next pointer 140h, read-only
// [RL4] Status bit 0 set on training error
// [RL5] Status bit 4 set on link protocol error
// [RL6] Status bit 12 set on poisoned TLP
// [RL7] Status bit 13 set on flow-control error
// [RL8] Status bit 14 set on completion timeout
// [RL9] Status bit 15 set on completer abort
// [RL10] Status bit 16 set on unexpected completion
// [RL11] Status bit 17 set on receiver overflow
// [RL12] Status bit 18 set on malformed TLP
// [RL13] Status bit 19 set on ECRC error
// [RL14] Status bit 20 set on unsupported request
// [RL15] Status bit 21 set on access violation
// [RL16] Mask bit 0 suppresses training error report
// [RL17] Mask bits 4, 12-20 suppress matching reports
// [RL18] Mask bit 21 suppresses access violation report
// [RL19] Masked events still set their status bit
// [RL20] Reserved bits read zero, ignore writes
`timescale 1ns/100ps
module aer_uncorrectable_error_regs #(
  parameter int ADDR_W = 12
) (
  // Clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Error events, one cycle per occurrence
  input wire logic i_training_err,
  input wire logic i_dl_protocol_err,
  input wire logic i_poisoned_tlp,
  input wire logic i_fc_protocol_err,
  input wire logic i_cpl_timeout,
  input wire logic i_cpl_abort,
  input wire logic i_unexp_cpl,
  input wire logic i_rx_overflow,
  input wire logic i_malformed_tlp,
  input wire logic i_ecrc_err,
  input wire logic i_unsup_req,
  input wire logic i_acs_violation,
  // Unmasked events toward header log and message logic
  output logic [31:0] o_report,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  // AXI4-Lite write data
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  // AXI4-Lite write response
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  // AXI4-Lite read data
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready
);

  // Decode compares full 12-bit offsets, so a narrower bus cannot work
  if (ADDR_W < 12) begin : g_addr_w_check
    $error("ADDR_W must be at least 12");
  end


  typedef enum logic [2:0] {
    WR_IDLE = 3'b001,
    WR_EXEC = 3'b010,
    WR_RESP = 3'b100
  } wr_state_t;

  wr_state_t wr_state_r;
  logic aw_held_r;
  logic w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [31:0] event_vec;
  logic [31:0] status_vec;
  logic [31:0] mask_vec;
  logic [31:0] report_vec;
  logic [31:0] wmask;
  logic wr_exec;
  logic wr_status;
  logic wr_mask;

  // Word-aligned decode, used by both read and write paths
  function automatic logic [1:0] decode(input logic [ADDR_W-1:0] addr);
    logic [11:0] a;
    a = {addr[11:2], 2'b00};
    // Shift keeps this legal when the bus is exactly 12 bits wide
    if ((addr >> 12) != '0) begin
      decode = 2'd3;
    end else if (a == aer_regs_pkg::CAP_HDR_OFS) begin
      decode = 2'd0;
    end else if (a == aer_regs_pkg::UNC_STATUS_OFS) begin
      decode = 2'd1;
    end else if (a == aer_regs_pkg::UNC_MASK_OFS) begin
      decode = 2'd2;
    end else begin
      decode = 2'd3;
    end
  endfunction : decode

  // Event vector in register layout
  always_comb begin
    event_vec = '0;
    // [RL4] training error
    event_vec[aer_regs_pkg::ERR_TRAINING] = i_training_err;
    // [RL5] link protocol error
    event_vec[aer_regs_pkg::ERR_DL_PROTOCOL] = i_dl_protocol_err;
    // [RL6] poisoned TLP
    event_vec[aer_regs_pkg::ERR_POISONED] = i_poisoned_tlp;
    // [RL7] flow control error
    event_vec[aer_regs_pkg::ERR_FC_PROTOCOL] = i_fc_protocol_err;
    // [RL8] completion timeout
    event_vec[aer_regs_pkg::ERR_CPL_TIMEOUT] = i_cpl_timeout;
    // [RL9] completer abort
    event_vec[aer_regs_pkg::ERR_CPL_ABORT] = i_cpl_abort;
    // [RL10] unexpected completion
    event_vec[aer_regs_pkg::ERR_UNEXP_CPL] = i_unexp_cpl;
    // [RL11] receiver overflow
    event_vec[aer_regs_pkg::ERR_RX_OVERFLOW] = i_rx_overflow;
    // [RL12] malformed TLP
    event_vec[aer_regs_pkg::ERR_MALFORMED] = i_malformed_tlp;
    // [RL13] ECRC error
    event_vec[aer_regs_pkg::ERR_ECRC] = i_ecrc_err;
    // [RL14] unsupported request
    event_vec[aer_regs_pkg::ERR_UNSUP_REQ] = i_unsup_req;
    // [RL15] access violation
    event_vec[aer_regs_pkg::ERR_ACS_VIOL] = i_acs_violation;
  end

  // Byte strobes widened to bit enables
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      wmask[i] = wstrb_r[i/8];
    end
  end

  assign wr_exec = (wr_state_r == WR_EXEC);
  assign wr_status = wr_exec && (decode(awaddr_r) == 2'd1);
  assign wr_mask = wr_exec && (decode(awaddr_r) == 2'd2);

  // [RL20] reserved bits have no flops
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_bit
      if (aer_regs_pkg::ERR_IMPL_MASK[g]) begin : g_impl
        // [RL19] set regardless of mask
        aer_err_bit u_bit (
          .i_mclk(i_mclk),
          .i_rst(i_rst),
          .i_ce(i_ce),
          .i_event(event_vec[g]),
          .i_w1c(wr_status & wmask[g] & wdata_r[g]),
          .i_mask_we(wr_mask & wmask[g]),
          .i_mask_wd(wdata_r[g]),
          .o_status(status_vec[g]),
          .o_mask(mask_vec[g]),
          .o_report(report_vec[g])
        );
      end else begin : g_rsvd
        assign status_vec[g] = 1'b0;
        assign mask_vec[g] = 1'b0;
        assign report_vec[g] = 1'b0;
      end
    end
  endgenerate

  // [RL16] [RL17] [RL18] masked events not reported
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_report <= '0;
    end else if (i_ce) begin
      o_report <= report_vec;
    end
  end

  // Write address and data taken in either order
  assign o_awready = (wr_state_r == WR_IDLE) && !aw_held_r;
  assign o_wready = (wr_state_r == WR_IDLE) && !w_held_r;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      aw_held_r <= 1'b0;
      awaddr_r <= '0;
    end else if (i_ce) begin
      if (o_awready && i_awvalid) begin
        aw_held_r <= 1'b1;
        awaddr_r <= i_awaddr;
      end else if (wr_exec) begin
        aw_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      w_held_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (i_ce) begin
      if (o_wready && i_wvalid) begin
        w_held_r <= 1'b1;
        wdata_r <= i_wdata;
        wstrb_r <= i_wstrb;
      end else if (wr_exec) begin
        w_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wr_state_r <= WR_IDLE;
      bresp_r <= aer_regs_pkg::RESP_OKAY;
    end else if (i_ce) begin
      case (wr_state_r)
        WR_IDLE: begin
          if (aw_held_r && w_held_r) begin
            wr_state_r <= WR_EXEC;
          end
        end
        WR_EXEC: begin
          // [RL1] [RL2] [RL3] header writes are ignored
          bresp_r <= (decode(awaddr_r) == 2'd3) ? aer_regs_pkg::RESP_SLVERR
                                                 : aer_regs_pkg::RESP_OKAY;
          wr_state_r <= WR_RESP;
        end
        WR_RESP: begin
          if (i_bready) begin
            wr_state_r <= WR_IDLE;
          end
        end
        default: begin
          wr_state_r <= WR_IDLE;
        end
      endcase
    end
  end

  assign o_bvalid = (wr_state_r == WR_RESP);
  assign o_bresp = bresp_r;

  // Reads answer one cycle after the address is taken
  assign o_arready = !rvalid_r;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= aer_regs_pkg::RESP_OKAY;
    end else if (i_ce) begin
      if (o_arready && i_arvalid) begin
        rvalid_r <= 1'b1;
        rresp_r <= aer_regs_pkg::RESP_OKAY;
        case (decode(i_araddr))
          2'd0: begin
            // [RL1] [RL2] [RL3] fixed header
            rdata_r <= {aer_regs_pkg::NEXT_PTR_RST, aer_regs_pkg::CAP_VER_VAL,
                        aer_regs_pkg::CAP_ID_VAL};
          end
          2'd1: begin
            rdata_r <= status_vec;
          end
          2'd2: begin
            rdata_r <= mask_vec;
          end
          default: begin
            rdata_r <= '0;
            rresp_r <= aer_regs_pkg::RESP_SLVERR;
          end
        endcase
      end else if (i_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  assign o_rvalid = rvalid_r;
  assign o_rdata = rdata_r;
  assign o_rresp = rresp_r;

endmodule : aer_uncorrectable_error_regs

/* File: aer_regs_pkg.sv */
// Purpose: Constants for the uncorrectable error reporting register slice
// Assumes: 32-bit AXI4-Lite register access, byte addresses as printed
// Notes: Status and mask share one layout of implemented bits
package aer_regs_pkg;

  // Register byte offsets
  localparam logic [11:0] CAP_HDR_OFS = 12'h100;
  localparam logic [11:0] UNC_STATUS_OFS = 12'h104;
  localparam logic [11:0] UNC_MASK_OFS = 12'h108;

  // Header fields
  localparam int CAP_ID_LSB = 0;
  localparam int CAP_VER_LSB = 16;
  localparam int NEXT_PTR_LSB = 20;
  localparam logic [15:0] CAP_ID_VAL = 16'h0001;
  localparam logic [3:0] CAP_VER_VAL = 4'h1;
  localparam logic [11:0] NEXT_PTR_RST = 12'h140;

  // Error bit positions
  localparam int ERR_TRAINING = 0;
  localparam int ERR_DL_PROTOCOL = 4;
  localparam int ERR_POISONED = 12;
  localparam int ERR_FC_PROTOCOL = 13;
  localparam int ERR_CPL_TIMEOUT = 14;
  localparam int ERR_CPL_ABORT = 15;
  localparam int ERR_UNEXP_CPL = 16;
  localparam int ERR_RX_OVERFLOW = 17;
  localparam int ERR_MALFORMED = 18;
  localparam int ERR_ECRC = 19;
  localparam int ERR_UNSUP_REQ = 20;
  localparam int ERR_ACS_VIOL = 21;

  // Implemented bits: 0, 4, 12..21
  localparam logic [31:0] ERR_IMPL_MASK = 32'h003F_F011;
  localparam logic [31:0] STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : aer_regs_pkg

/* File: aer_err_bit.sv */
// Purpose: One sticky write-one-to-clear error bit with its mask bit
// Assumes: Event input is on the core clock
// Notes: Set wins over a clear in the same cycle
`timescale 1ns/100ps
module aer_err_bit (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Event and software access
  input wire logic i_event,
  input wire logic i_w1c,
  input wire logic i_mask_we,
  input wire logic i_mask_wd,
  // State
  output logic o_status,
  output logic o_mask,
  output logic o_report
);

  // Status sets even when masked
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_status <= 1'b0;
    end else if (i_ce) begin
      o_status <= i_event | (o_status & ~i_w1c);
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_mask <= 1'b0;
    end else if (i_ce && i_mask_we) begin
      o_mask <= i_mask_wd;
    end
  end

  // Mask only gates logging and messaging
  assign o_report = i_event & ~o_mask;

endmodule : aer_err_bit

/* File: err_event_src.sv */
// Purpose: Error event sources on the far side of the register slice
// Assumes: One occurrence is a single-cycle pulse on the core clock
// Notes: Events change just after an edge, as real source logic would
`timescale 1ns/100ps
module err_event_src (
  // Clock
  input wire logic i_mclk,
  // Requests and events
  input wire logic [11:0] i_kick,
  output logic [11:0] o_ev
);
  initial o_ev = 12'h000;
  always @(posedge i_mclk) begin
    o_ev <= i_kick;
  end
endmodule : err_event_src

/* File: aer_regs_checker.sv */
// Purpose: Port assertions for the uncorrectable error register slice
// Assumes: One clock, asynchronous active-high reset
// Notes: Read offset is tracked here to judge each read beat
`timescale 1ns/100ps
module aer_regs_checker #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Events and report
  input wire logic i_training_err,
  input wire logic i_dl_protocol_err,
  input wire logic i_acs_violation,
  input wire logic [31:0] o_report,
  // Read channels
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic o_rvalid
);
  logic [11:0] rd_ofs_r;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rd_ofs_r <= 12'h000;
    end else if (i_ce && i_arvalid && o_arready) begin
      rd_ofs_r <= {i_araddr[11:2], 2'h0};
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  sequence s_hdr_beat;
    o_rvalid && rd_ofs_r == 12'h100;
  endsequence
  sequence s_reg_beat;
    o_rvalid && rd_ofs_r != 12'h100;
  endsequence
  property p_cap_id;
    s_hdr_beat |-> o_rdata[15:0] == 16'h0001;
  endproperty
  a_cap_id: assert property (p_cap_id) else $error("header id wrong");
  property p_cap_ver;
    s_hdr_beat |-> o_rdata[19:16] == 4'h1;
  endproperty
  a_cap_ver: assert property (p_cap_ver) else $error("header version wrong");
  property p_nxt_ptr;
    s_hdr_beat |-> o_rdata[31:20] == 12'h140;
  endproperty
  a_nxt_ptr: assert property (p_nxt_ptr) else $error("next pointer wrong");
  property p_rsv_zero;
    s_reg_beat |-> (o_rdata & 32'hFFC0_0FEE) == 32'h0000_0000;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits set");
  property p_rpt_rsv;
    (o_report & 32'hFFC0_0FEE) == 32'h0000_0000;
  endproperty
  a_rpt_rsv: assert property (p_rpt_rsv) else $error("report on unused bit");
  property p_rpt_train;
    o_report[0] |-> $past(i_training_err) || !$past(i_ce);
  endproperty
  a_rpt_train: assert property (p_rpt_train) else $error("report 0 uncaused");
  property p_rpt_dl;
    o_report[4] |-> $past(i_dl_protocol_err) || !$past(i_ce);
  endproperty
  a_rpt_dl: assert property (p_rpt_dl) else $error("report 4 uncaused");
  property p_rpt_acs;
    o_report[21] |-> $past(i_acs_violation) || !$past(i_ce);
  endproperty
  a_rpt_acs: assert property (p_rpt_acs) else $error("report 21 uncaused");
endmodule : aer_regs_checker
bind aer_uncorrectable_error_regs aer_regs_checker #(.ADDR_W(ADDR_W)) u_chk (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_training_err(i_training_err),
  .i_dl_protocol_err(i_dl_protocol_err), .i_acs_violation(i_acs_violation),
  .o_report(o_report), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
  .o_arready(o_arready), .o_rdata(o_rdata), .o_rvalid(o_rvalid)
);

/* File: testbench.sv */
// Purpose: Self-checking bench for the uncorrectable error register slice
// Assumes: AXI4-Lite master tasks, events from the source model
// Notes: Mask and status expectations are kept by bench functions
`timescale 1ns/100ps
module testbench;
  logic clk = 1'h0;
  logic rst = 1'h0;
  logic ce = 1'h1;
  logic [11:0] kick = 12'h000;
  logic [11:0] ev;
  logic [31:0] rpt, rdata, wdata = 32'h0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] seed = 32'h2;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  always #25 clk = ~clk;
  err_event_src src (.i_mclk(clk), .i_kick(kick), .o_ev(ev));
  aer_uncorrectable_error_regs dut (
    .i_mclk(clk), .i_rst(rst), .i_ce(ce),
    .i_training_err(ev[0]), .i_dl_protocol_err(ev[1]), .i_poisoned_tlp(ev[2]),
    .i_fc_protocol_err(ev[3]), .i_cpl_timeout(ev[4]), .i_cpl_abort(ev[5]),
    .i_unexp_cpl(ev[6]), .i_rx_overflow(ev[7]), .i_malformed_tlp(ev[8]),
    .i_ecrc_err(ev[9]), .i_unsup_req(ev[10]), .i_acs_violation(ev[11]), .o_report(rpt),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready)
  );
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Event index to status bit: 0, 4, then 12 upward
  function automatic logic [31:0] bits(input logic [11:0] v);
    return {10'h000, v[11:2], 7'h00, v[1], 3'h0, v[0]};
  endfunction : bits
  function automatic logic [31:0] lanes(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : lanes
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic ad;
    logic dd;
    ad = 1'h0;
    dd = 1'h0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(ad && dd)) begin
      @(posedge clk);
      ad |= (awready === 1'h1);
      dd |= (wready === 1'h1);
      awvalid <= !ad;
      wvalid <= !dd;
    end
    do @(posedge clk); while (bvalid !== 1'h1);
    bready <= 1'h0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge clk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge clk); while (rvalid !== 1'h1);
    rready <= 1'h0;
    d = rdata;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    @(posedge clk);
  endtask : rd
  // Report is a pulse one cycle after the event reaches the slice
  task automatic fire(input logic [11:0] v, input logic [31:0] em);
    kick <= v;
    @(posedge clk);
    kick <= 12'h000;
    @(posedge clk);
    @(negedge clk);
    chk("report", em, rpt);
    @(posedge clk);
  endtask : fire
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    logic [31:0] d, m, r;
    logic [11:0] v;
    rst <= 1'h1;
    m = 32'h0;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rd(12'h100, 2'h0, d);
    chk("header", 32'h1401_0001, d);
    rd(12'h104, 2'h0, d);
    chk("status reset", 32'h0, d);
    rd(12'h108, 2'h0, d);
    chk("mask reset", 32'h0, d);
    wr(12'h100, 32'hFFFF_FFFF, 4'hF, 2'h0);
    rd(12'h100, 2'h0, d);
    chk("header kept", 32'h1401_0001, d);
    wr(12'h110, 32'hFFFF_FFFF, 4'hF, 2'h2);
    rd(12'h10C, 2'h2, d);
    chk("unmapped", 32'h0, d);
    // A frozen slice drops events and holds its report
    ce <= 1'h0;
    fire(12'hFFF, 32'h0);
    ce <= 1'h1;
    rd(12'h104, 2'h0, d);
    chk("frozen status", 32'h0, d);
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      v = 12'h001 << i;
      fire(v, bits(v));
      rd(12'h104, 2'h0, d);
      chk("status set", bits(v), d);
      wr(12'h104, bits(v), 4'hF, 2'h0);
      rd(12'h104, 2'h0, d);
      chk("status clear", 32'h0, d);
    end
    $display("test events done");
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      wr(12'h108, r, r[7:4], 2'h0);
      m = (m & ~lanes(r[7:4])) | (r & lanes(r[7:4]) & 32'h003F_F011);
      rd(12'h108, 2'h0, d);
      chk("mask", m, d);
      r = rnd();
      v = r[11:0];
      fire(v, bits(v) & ~m);
      rd(12'h104, 2'h0, d);
      chk("masked status", bits(v), d);
      r = rnd();
      wr(12'h104, r, 4'hF, 2'h0);
      rd(12'h104, 2'h0, d);
      chk("partial clear", bits(v) & ~r, d);
      wr(12'h104, 32'hFFFF_FFFF, 4'hF, 2'h0);
    end
    $display("test masks done");
    // Sticky status and mask must both drop on a reset in mid-run
    wr(12'h108, 32'hFFFF_FFFF, 4'hF, 2'h0);
    fire(12'hFFF, 32'h0);
    rd(12'h104, 2'h0, d);
    chk("all status", 32'h003F_F011, d);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rd(12'h104, 2'h0, d);
    chk("status after reset", 32'h0, d);
    rd(12'h108, 2'h0, d);
    chk("mask after reset", 32'h0, d);
    $display("test mid reset done");
    test_done();
  end
endmodule : testbench
